/* verilog/psio_pkg.sv */
// package for the packed simd integer datapath: widths, opcodes, field layout
// assumes a single core clock; operands arrive already fetched
package psio_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VEC_W   = 128;
  localparam int BYTE_W  = 8;
  localparam int WORD_W  = 16;
  localparam int DWORD_W = 32;
  localparam int QWORD_W = 64;
  localparam int IMM_W   = 8;
  localparam int NBYTES  = VEC_W / BYTE_W;
  localparam int NWORDS  = VEC_W / WORD_W;
  localparam int NDWORDS = VEC_W / DWORD_W;
  localparam int NLANES  = VEC_W / QWORD_W;
  localparam int SAD_N   = 8;
  localparam int SAD_PAIRS = 4;

  // ---------------------------------------------------------------
  // field layout and limits
  // ---------------------------------------------------------------
  localparam logic [IMM_W-1:0] SHIFT_MAX  = 8'h0f;
  localparam int               SAD_SRC_SEL = 2;
  localparam int               SAD_DST_SEL = 0;
  localparam int               MINPOS_IDX_LSB = 16;
  localparam int               MINPOS_IDX_W   = 3;
  localparam int               ZERO_FLAG_POS  = 6;
  localparam int               CARRY_FLAG_POS = 0;
  localparam int               FLAGS_W = 32;
  localparam logic [VEC_W-1:0]   VEC_RST   = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 32'h0000_0002;

  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PSIO_OP_SAD,
    PSIO_OP_MINPOS,
    PSIO_OP_AVG_B,
    PSIO_OP_AVG_W,
    PSIO_OP_MADD,
    PSIO_OP_ADDQ,
    PSIO_OP_SUBQ,
    PSIO_OP_SHL_B,
    PSIO_OP_SHR_B,
    PSIO_OP_TEST
  } psio_op_t;

endpackage

/* verilog/psio_avg_lane.sv */
// one averaging element: rounded mean of two unsigned values
// assumes combinational use inside the datapath top
`timescale 1ns/1ps
`default_nettype none
module psio_avg_lane #(
  parameter int W = 8
) (
  // operands
  input  wire logic [W-1:0] dst_el,
  input  wire logic [W-1:0] src_el,
  // result
  output logic      [W-1:0] avg_el
);
  // ---------------------------------------------------------------
  // sum one bit wider so the carry out survives
  // ---------------------------------------------------------------
  logic [W:0] sum;
  assign sum    = {1'b0, dst_el} + {1'b0, src_el} + {{W{1'b0}}, 1'b1};
  assign avg_el = sum[W:1];
endmodule
`default_nettype wire

/* verilog/psio_datapath.sv */
// packed simd integer datapath: one registered result per issued operation
// assumes decode supplies operands (register or memory fetch) with op_valid
//
// Function
// - eight SADs, four byte pairs, word results
// - averaging adds with carry-in one, wider
// - shift right, top bit from carry
// - byte variant bytes, word variant words
// - vector destination, source register or memory
// - signed word products, adjacent pairs summed
// - coefficient layout yields complex product
// - pair sums written as 32-bit doublewords
// - quadword add/sub independent per lane
// - overflow wraps, no carry across lanes
// - full form two lanes, half form one
// - byte shifts by immediate, zero fill
// - count above 15 clears the result
// - bit test writes only zero, carry flags
`timescale 1ns/1ps
`default_nettype none
module psio_datapath
  import psio_pkg::*;
(
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  // issue from decode
  input  wire logic                           op_valid,
  input  wire psio_pkg::psio_op_t             op_code,
  input  wire logic                           op_half,
  input  wire logic [psio_pkg::VEC_W-1:0]     dst_in,
  input  wire logic [psio_pkg::VEC_W-1:0]     src_in,
  input  wire logic [psio_pkg::IMM_W-1:0]     imm_in,
  input  wire logic [psio_pkg::FLAGS_W-1:0]   flags_in,
  // results
  output logic                                res_valid,
  output logic                                res_vec_we,
  output logic [psio_pkg::VEC_W-1:0]          res_vec,
  output logic                                res_flags_we,
  output logic [psio_pkg::FLAGS_W-1:0]        status_flags_word
);
  import psio_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  // release synchronised so every flop leaves reset on the same edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // multi_block_sad: block j compares dst bytes j..j+3 with src bytes 8..11
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] sad_word [SAD_N];
  genvar gs, gp;
  generate
    for (gs = 0; gs < SAD_N; gs++) begin : g_sad
      logic [WORD_W-1:0] part [SAD_PAIRS];
      for (gp = 0; gp < SAD_PAIRS; gp++) begin : g_pair
        logic [BYTE_W-1:0] a;
        logic [BYTE_W-1:0] b;
        assign a = dst_in[(SAD_DST_SEL*4+gs+gp)*BYTE_W +: BYTE_W];
        assign b = src_in[(SAD_SRC_SEL*4+gp)*BYTE_W +: BYTE_W];
        // unsigned absolute difference, zero extended
        assign part[gp] = {8'h00, (a > b) ? (a - b) : (b - a)};
      end
      assign sad_word[gs] = part[0] + part[1] + part[2] + part[3];
    end
  endgenerate

  // ---------------------------------------------------------------
  // horizontal_min_position over eight unsigned words of src
  // ---------------------------------------------------------------
  logic [WORD_W-1:0]       min_val;
  logic [MINPOS_IDX_W-1:0] min_idx;
  // strict less-than keeps the lowest index on ties
  always_comb begin
    min_val = src_in[WORD_W-1:0];
    min_idx = '0;
    for (int i = 1; i < NWORDS; i++) begin
      if (src_in[i*WORD_W +: WORD_W] < min_val) begin
        min_val = src_in[i*WORD_W +: WORD_W];
        min_idx = MINPOS_IDX_W'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // byte_average and word_average; src may be register or memory data
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] avg_b;
  logic [VEC_W-1:0] avg_w;
  genvar ga;
  generate
    for (ga = 0; ga < NBYTES; ga++) begin : g_avgb
      psio_avg_lane #(.W(BYTE_W)) u_avg (
        .dst_el (dst_in[ga*BYTE_W +: BYTE_W]),
        .src_el (src_in[ga*BYTE_W +: BYTE_W]),
        .avg_el (avg_b[ga*BYTE_W +: BYTE_W])
      );
    end
    for (ga = 0; ga < NWORDS; ga++) begin : g_avgw
      psio_avg_lane #(.W(WORD_W)) u_avg (
        .dst_el (dst_in[ga*WORD_W +: WORD_W]),
        .src_el (src_in[ga*WORD_W +: WORD_W]),
        .avg_el (avg_w[ga*WORD_W +: WORD_W])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // word multiply-pair-add into doublewords
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] madd;
  genvar gm;
  generate
    for (gm = 0; gm < NDWORDS; gm++) begin : g_madd
      logic signed [DWORD_W-1:0] p0;
      logic signed [DWORD_W-1:0] p1;
      assign p0 = $signed(dst_in[gm*DWORD_W +: WORD_W])
                * $signed(src_in[gm*DWORD_W +: WORD_W]);
      assign p1 = $signed(dst_in[gm*DWORD_W+WORD_W +: WORD_W])
                * $signed(src_in[gm*DWORD_W+WORD_W +: WORD_W]);
      // [cr -ci ci cr] coefficients give re and im parts in adjacent dwords
      assign madd[gm*DWORD_W +: DWORD_W] = p0 + p1;
    end
  endgenerate

  // ---------------------------------------------------------------
  // quadword lane add / subtract, wrapping per lane
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] addq;
  logic [VEC_W-1:0] subq;
  genvar gq;
  generate
    for (gq = 0; gq < NLANES; gq++) begin : g_q
      // 64-bit targets drop the carry, so lanes stay apart
      assign addq[gq*QWORD_W +: QWORD_W] = dst_in[gq*QWORD_W +: QWORD_W]
                                         + src_in[gq*QWORD_W +: QWORD_W];
      assign subq[gq*QWORD_W +: QWORD_W] = dst_in[gq*QWORD_W +: QWORD_W]
                                         - src_in[gq*QWORD_W +: QWORD_W];
    end
  endgenerate

  // ---------------------------------------------------------------
  // whole-register byte shifts
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] shl_b;
  logic [VEC_W-1:0] shr_b;
  logic             shift_big;
  assign shift_big = imm_in > SHIFT_MAX;
  assign shl_b = shift_big ? '0 : (dst_in << {imm_in[3:0], 3'b000});
  assign shr_b = shift_big ? '0 : (dst_in >> {imm_in[3:0], 3'b000});

  // ---------------------------------------------------------------
  // bit test flags
  // ---------------------------------------------------------------
  logic test_zero;
  logic test_carry;
  assign test_zero  = ~|(dst_in & src_in);
  assign test_carry = ~|(src_in & ~dst_in);

  // ---------------------------------------------------------------
  // result select
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] vec_d;
  logic             vec_we_d;
  always_comb begin
    vec_we_d = 1'b1;
    vec_d    = '0;
    case (op_code)
      PSIO_OP_SAD: begin
        for (int i = 0; i < SAD_N; i++) vec_d[i*WORD_W +: WORD_W] = sad_word[i];
      end
      PSIO_OP_MINPOS: begin
        vec_d[WORD_W-1:0] = min_val;
        vec_d[MINPOS_IDX_LSB +: MINPOS_IDX_W] = min_idx;
      end
      PSIO_OP_AVG_B:  vec_d = avg_b;
      PSIO_OP_AVG_W:  vec_d = avg_w;
      PSIO_OP_MADD:   vec_d = madd;
      PSIO_OP_ADDQ:   vec_d = addq;
      PSIO_OP_SUBQ:   vec_d = subq;
      PSIO_OP_SHL_B:  vec_d = shl_b;
      PSIO_OP_SHR_B:  vec_d = shr_b;
      PSIO_OP_TEST:   vec_we_d = 1'b0;
      default:        vec_we_d = 1'b0;
    endcase
    // half form: both lanes are computed, then the high half is zeroed
    if (op_half && (op_code == PSIO_OP_ADDQ || op_code == PSIO_OP_SUBQ)) begin
      vec_d[VEC_W-1:QWORD_W] = '0;
    end
  end

  // vector result registers; a bit test leaves the last vector result standing
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_valid  <= 1'b0;
      res_vec_we <= 1'b0;
      res_vec    <= VEC_RST;
    end else begin
      res_valid  <= op_valid;
      res_vec_we <= op_valid & vec_we_d;
      res_vec    <= (op_valid && vec_we_d) ? vec_d : res_vec;
    end
  end

  // flags: other bits pass through untouched from decode
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_flags_we      <= 1'b0;
      status_flags_word <= FLAGS_RST;
    end else begin
      res_flags_we <= op_valid && op_code == PSIO_OP_TEST;
      if (op_valid && op_code == PSIO_OP_TEST) begin
        status_flags_word         <= flags_in;
        status_flags_word[ZERO_FLAG_POS]  <= test_zero;
        status_flags_word[CARRY_FLAG_POS] <= test_carry;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence test_issue_s;
    op_valid && op_code == PSIO_OP_TEST;
  endsequence

  test_no_vec_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    test_issue_s |=> res_flags_we && !res_vec_we)
    else $error("bit test wrote a vector result");
  test_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    test_issue_s |=> $stable(res_vec))
    else $error("bit test changed the vector result");
  test_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    test_issue_s |=> status_flags_word[ZERO_FLAG_POS] == ~|($past(dst_in) & $past(src_in)))
    else $error("zero flag wrong after bit test");
  test_carry_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    test_issue_s |=> status_flags_word[CARRY_FLAG_POS] == ~|($past(src_in) & ~$past(dst_in)))
    else $error("carry flag wrong after bit test");
  shift_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && (op_code == PSIO_OP_SHL_B || op_code == PSIO_OP_SHR_B) && imm_in > SHIFT_MAX
    |=> res_vec == '0)
    else $error("oversized byte shift left data");
  addq_lane_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && op_code == PSIO_OP_ADDQ && !op_half
    |=> res_vec[VEC_W-1:QWORD_W] == QWORD_W'($past(dst_in[VEC_W-1:QWORD_W])
                                   + $past(src_in[VEC_W-1:QWORD_W])))
    else $error("high lane add leaked a carry");
  half_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && op_half && (op_code == PSIO_OP_ADDQ || op_code == PSIO_OP_SUBQ)
    |=> res_vec[VEC_W-1:QWORD_W] == '0)
    else $error("half form touched high lane");
  minpos_top_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && op_code == PSIO_OP_MINPOS
    |=> res_vec[VEC_W-1:MINPOS_IDX_LSB+MINPOS_IDX_W] == '0
        && res_vec[WORD_W-1:0] <= $past(src_in[WORD_W-1:0]))
    else $error("minimum position result malformed");
  avg_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && op_code == PSIO_OP_AVG_B
    |=> res_vec[7:0] == 8'((9'($past(dst_in[7:0])) + 9'($past(src_in[7:0])) + 9'd1) >> 1))
    else $error("byte average low element wrong");
  valid_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    op_valid && op_code != PSIO_OP_TEST |=> res_valid && res_vec_we)
    else $error("vector result not written");

endmodule
`default_nettype wire

/* verification/psio_decode_model.sv */
// decode and register-file model: turns one bench request into one issue
// assumes the bench pulses req_go for one cycle per operation
`timescale 1ns/1ps
`default_nettype none
module psio_decode_model
  import psio_pkg::*;
(
  // clock
  input  wire logic                         sys_clk,
  // request from bench
  input  wire logic                         req_go,
  input  wire psio_pkg::psio_op_t           req_code,
  input  wire logic                         req_half,
  input  wire logic [psio_pkg::VEC_W-1:0]   req_dst,
  input  wire logic [psio_pkg::VEC_W-1:0]   req_src,
  input  wire logic [psio_pkg::IMM_W-1:0]   req_imm,
  input  wire logic [psio_pkg::FLAGS_W-1:0] req_flags,
  // issue to datapath
  output logic                              op_valid,
  output psio_pkg::psio_op_t                op_code,
  output logic                              op_half,
  output logic [psio_pkg::VEC_W-1:0]        dst_in,
  output logic [psio_pkg::VEC_W-1:0]        src_in,
  output logic [psio_pkg::IMM_W-1:0]        imm_in,
  output logic [psio_pkg::FLAGS_W-1:0]      flags_in
);
  import psio_pkg::*;

  // ---------------------------------------------------------------
  // issue register
  // ---------------------------------------------------------------
  // quiet values defined at time zero
  initial begin
    op_valid = 1'b0;
    op_code  = PSIO_OP_SAD;
    op_half  = 1'b0;
    dst_in   = '0;
    src_in   = '0;
    imm_in   = '0;
    flags_in = '0;
  end
  // operands toggle between issues so a late sample never sees stale data
  always @(posedge sys_clk) begin
    op_valid <= req_go;
    if (req_go) begin
      op_code  <= req_code;
      op_half  <= req_half;
      dst_in   <= req_dst;
      src_in   <= req_src;
      imm_in   <= req_imm;
      flags_in <= req_flags;
    end else begin
      dst_in   <= ~dst_in;
      src_in   <= ~src_in;
      imm_in   <= ~imm_in;
      flags_in <= ~flags_in;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_packed_simd_integer_ops.sv */
// bench for the packed simd datapath: one task per operation family
// assumes the decode model sits between bench and datapath
`timescale 1ns/1ps
`default_nettype none
module tb_packed_simd_integer_ops;
  import psio_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, req_go = 1'b0, req_half = 1'b0;
  psio_op_t req_code = PSIO_OP_SAD;
  logic [VEC_W-1:0] req_dst = '0, req_src = '0;
  logic [IMM_W-1:0] req_imm = '0;
  logic [FLAGS_W-1:0] req_flags = '0;
  logic op_valid, op_half, res_valid, res_vec_we, res_flags_we;
  psio_op_t op_code;
  logic [VEC_W-1:0] dst_in, src_in, res_vec;
  logic [IMM_W-1:0] imm_in;
  logic [FLAGS_W-1:0] flags_in, status_flags_word;
  int mismatches = 0, n_tests = 0;

  always #10 sys_clk = ~sys_clk;

  psio_decode_model MDL (.sys_clk(sys_clk), .req_go(req_go), .req_code(req_code),
    .req_half(req_half), .req_dst(req_dst), .req_src(req_src), .req_imm(req_imm),
    .req_flags(req_flags), .op_valid(op_valid), .op_code(op_code), .op_half(op_half),
    .dst_in(dst_in), .src_in(src_in), .imm_in(imm_in), .flags_in(flags_in));
  psio_datapath DUT (.sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid),
    .op_code(op_code), .op_half(op_half), .dst_in(dst_in), .src_in(src_in),
    .imm_in(imm_in), .flags_in(flags_in), .res_valid(res_valid), .res_vec_we(res_vec_we),
    .res_vec(res_vec), .res_flags_we(res_flags_we), .status_flags_word(status_flags_word));

  // ---------------------------------------------------------------
  // reference and helpers
  // ---------------------------------------------------------------
  function automatic logic [127:0] ref_vec(psio_op_t c, logic h, logic [127:0] d, s,
                                           logic [7:0] im);
    logic [127:0] r;
    int a, b, acc, m, ix;
    r = '0;
    case (c)
      PSIO_OP_SAD: for (int j = 0; j < 8; j++) begin
        acc = 0;
        for (int k = 0; k < 4; k++) begin
          a = d[8*(j+k)+:8];
          b = s[8*(8+k)+:8];
          acc += (a > b) ? a - b : b - a;
        end
        r[16*j+:16] = 16'(acc);
      end
      PSIO_OP_MINPOS: begin
        m = s[15:0];
        ix = 0;
        for (int j = 1; j < 8; j++) if (s[16*j+:16] < m) begin
          m = s[16*j+:16];
          ix = j;
        end
        r[15:0] = 16'(m);
        r[18:16] = 3'(ix);
      end
      PSIO_OP_AVG_B: for (int j = 0; j < 16; j++) r[8*j+:8] = 8'((d[8*j+:8] + s[8*j+:8] + 1) >> 1);
      PSIO_OP_AVG_W: for (int j = 0; j < 8; j++) r[16*j+:16] = 16'((int'(d[16*j+:16]) + s[16*j+:16] + 1) >> 1);
      PSIO_OP_MADD: for (int i = 0; i < 4; i++) begin
        // products in int so the 16x16 multiply keeps all 32 bits
        a = $signed(d[32*i+:16]) * $signed(s[32*i+:16]);
        b = $signed(d[32*i+16+:16]) * $signed(s[32*i+16+:16]);
        r[32*i+:32] = 32'(a + b);
      end
      PSIO_OP_ADDQ: r = {d[127:64] + s[127:64], d[63:0] + s[63:0]};
      PSIO_OP_SUBQ: r = {d[127:64] - s[127:64], d[63:0] - s[63:0]};
      PSIO_OP_SHL_B: r = (im > 8'h0f) ? '0 : d << (8 * im);
      PSIO_OP_SHR_B: r = (im > 8'h0f) ? '0 : d >> (8 * im);
      default: r = '0;
    endcase
    if (h && (c == PSIO_OP_ADDQ || c == PSIO_OP_SUBQ)) r[127:64] = '0;
    return r;
  endfunction

  task automatic check(string nm, logic [127:0] seen, logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // issue one op and wait, bounded, for its result pulse
  task automatic run_op(psio_op_t c, logic h, logic [127:0] d, s, logic [7:0] im,
                        logic [31:0] f);
    int n;
    @(posedge sys_clk);
    req_go <= 1'b1; req_code <= c; req_half <= h;
    req_dst <= d; req_src <= s; req_imm <= im; req_flags <= f;
    @(posedge sys_clk);
    req_go <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (res_valid !== 1'b1 && n < 8);
    check("res_valid", 128'(res_valid), 128'(1));
  endtask

  task automatic vec_op(psio_op_t c, logic h, logic [127:0] d, s, logic [7:0] im);
    run_op(c, h, d, s, im, 32'h0000_0000);
    check("res_vec_we", 128'(res_vec_we), 128'(1));
    check("res_flags_we", 128'(res_flags_we), 128'(0));
    check("res_vec", res_vec, ref_vec(c, h, d, s, im));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_sad();
    vec_op(PSIO_OP_SAD, 0, 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0,
           128'hff00_807f_1234_5678_0102_0304_0506_0708, 0);
    vec_op(PSIO_OP_SAD, 0, '0, '1, 0);
  endtask

  task automatic t_minpos();
    vec_op(PSIO_OP_MINPOS, 0, '1, 128'h0009_0003_8000_0003_ffff_0004_7fff_0005, 0);
    vec_op(PSIO_OP_MINPOS, 0, '1, 128'h0000_0001_0002_0003_0004_0005_0006_0007, 0);
  endtask

  task automatic t_avg();
    logic [127:0] d = 128'hffff_ff00_0102_8000_fffe_0001_7f80_00ff;
    vec_op(PSIO_OP_AVG_B, 0, d, '1, 0);
    vec_op(PSIO_OP_AVG_W, 0, d, 128'hffff_00ff_0001_8000_0001_0000_8080_ff01, 0);
    vec_op(PSIO_OP_AVG_B, 0, d, 128'hffff_00ff_0001_8000_0001_0000_8080_ff01, 0);
  endtask

  task automatic t_madd();
    vec_op(PSIO_OP_MADD, 0, 128'h8000_8000_7fff_8000_fffe_0003_fffe_0003,
           128'h8000_8000_7fff_7fff_0005_0007_fff9_0005, 0);
    check("complex_pair", res_vec[63:0], {32'd11, 32'd29});
    check("complex_dword3", res_vec[127:96], 32'h8000_0000);
  endtask

  task automatic t_qadd();
    for (int h = 0; h < 2; h++) begin
      vec_op(PSIO_OP_ADDQ, h[0], {64'h7fff_ffff_ffff_ffff, 64'hffff_ffff_ffff_ffff},
             {64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001}, 0);
      vec_op(PSIO_OP_SUBQ, h[0], {64'h8000_0000_0000_0000, 64'h0000_0000_0000_0000},
             {64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001}, 0);
    end
  endtask

  task automatic t_shift();
    logic [7:0] cnt [5] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'hff};
    foreach (cnt[i]) begin
      vec_op(PSIO_OP_SHL_B, 0, 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, '1, cnt[i]);
      vec_op(PSIO_OP_SHR_B, 0, 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, '1, cnt[i]);
    end
  endtask

  // zero flag at bit 6, carry flag at bit 0, others pass through
  task automatic t_test(logic [127:0] a, b, logic [31:0] f);
    logic [31:0] e;
    logic [127:0] keep;
    e = f;
    e[6] = ((a & b) == '0);
    e[0] = ((b & ~a) == '0);
    keep = res_vec;
    run_op(PSIO_OP_TEST, 0, a, b, 0, f);
    check("test_vec_hold", res_vec, keep);
    check("test_vec_we", 128'(res_vec_we), 128'(0));
    check("test_flags_we", 128'(res_flags_we), 128'(1));
    check("flags", 128'(status_flags_word), 128'(e));
  endtask

  // mid-run reset: results clear, flags word back to its reset value
  task automatic t_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("rst_flags", 128'(status_flags_word), 128'(FLAGS_RST));
    check("rst_flags_we", 128'(res_flags_we), 128'(0));
    check("rst_vec", res_vec, VEC_RST);
    check("rst_valid", 128'(res_valid), 128'(0));
    @(posedge sys_clk);
    arst_n <= 1'b1;
    // two synchroniser edges plus one before the next issue
    repeat (3) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_sad();
    t_minpos();
    t_avg();
    t_madd();
    t_qadd();
    t_shift();
    t_reset();
    t_test({64'hf0f0_f0f0_f0f0_f0f0, 64'h0}, {64'h0f0f_0f0f_0f0f_0f0f, 64'h1}, 32'hffff_ffff);
    t_test('1, 128'h0000_1000_0000_0000_0000_0000_0000_0001, 32'h0000_0000);
    t_test('0, '0, 32'h0000_0002);
    stop_test();
  end

  // run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
